/* File: impedance_cal_map.svh */
// Constants for the impedance calibration block.
`ifndef IMPEDANCE_CAL_MAP_SVH
`define IMPEDANCE_CAL_MAP_SVH
`define CLOCK_PERIOD_NS      10
`define INIT_CAL_PERIOD_CK   512
`define FULL_CAL_PERIOD_CK   256
`define SHORT_CAL_PERIOD_CK  64
`define CODE_WIDTH           6
`define CODE_RESET           6'h20
`define CAL_CMD_CODE         3'h6
`define LONG_SELECT_BIT      10
`endif

/* File: impedance_cal_pkg.sv */
// Types shared by the impedance calibration block.
package impedance_cal_pkg;
  typedef enum logic [1:0] {
    IDLE_STATE  = 2'b00,
    SEARCH_STATE = 2'b01,
    TRANSFER_STATE = 2'b10
  } cal_state_type;
endpackage

/* File: cal_engine_if.sv */
// Handshake between the calibration sequencer and its search engine.
`timescale 1ns/1ps
interface cal_engine_if;
  logic       start;
  logic [5:0] result;
  logic       done;
  modport sequencer (output start, input result, input done);
  modport engine    (input start, output result, output done);
endinterface

/* File: cal_search_engine.sv */
// Successive-approximation search of one impedance code against the reference pin.
`timescale 1ns/1ps
`include "impedance_cal_map.svh"
module cal_search_engine
  import impedance_cal_pkg::*;
(
  input wire logic   clock,
  input wire logic   rst_n,
  input wire logic   compare_high,
  cal_engine_if.engine eng
);
  logic [`CODE_WIDTH-1:0] trial;
  logic [`CODE_WIDTH-1:0] bit_mask;
  logic                   busy;

  // One code bit is decided per cycle, most significant first.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      trial    <= `CODE_RESET;
      bit_mask <= `CODE_RESET;
      busy     <= 1'b0;
      eng.done <= 1'b0;
      eng.result <= `CODE_RESET;
    end else begin
      eng.done <= 1'b0;
      if (eng.start && !busy) begin
        busy     <= 1'b1;
        bit_mask <= `CODE_RESET;
        trial    <= `CODE_RESET;
      end else if (busy) begin
        if (bit_mask == {`CODE_WIDTH{1'b0}}) begin
          busy       <= 1'b0;
          eng.done   <= 1'b1;
          eng.result <= trial;
        end else begin
          trial <= (compare_high ? trial : (trial & ~bit_mask)) | (bit_mask >> 1);
          bit_mask <= bit_mask >> 1;
        end
      end
    end
  end
endmodule // cal_search_engine

/* File: impedance_calibration.sv */
// Driver and termination impedance calibration sequencer of the memory device.
`timescale 1ns/1ps
`include "impedance_cal_map.svh"
module impedance_calibration
  import impedance_cal_pkg::*;
#(
  parameter int INIT_CYCLES  = `INIT_CAL_PERIOD_CK,
  parameter int FULL_CYCLES  = `FULL_CAL_PERIOD_CK,
  parameter int SHORT_CYCLES = `SHORT_CAL_PERIOD_CK
) (
  input  wire logic        CLOCK,
  input  wire logic        RST_N,
  input  wire logic        CMD_VALID,
  input  wire logic [2:0]  CMD_CODE,
  input  wire logic [13:0] ADDRESS,
  input  wire logic        SELF_REFRESH_EXIT,
  input  wire logic        PULLDOWN_COMPARE_HIGH,
  input  wire logic        TERMINATION_COMPARE_HIGH,
  output logic [5:0]       DRIVER_CODE,
  output logic [5:0]       TERMINATION_CODE,
  output logic             CAL_CURRENT_ENABLE,
  output logic             CAL_BUSY,
  output logic             CAL_LONG_ACTIVE
);
  cal_state_type state;
  logic [15:0]   window_count;
  logic          first_long_done;
  logic          drive_done;
  logic          term_done;
  logic          search_done;
  // Results of the two engines, valid once the matching done flag is set.
  logic [5:0]    drive_result;
  logic [5:0]    term_result;
  logic          cal_cmd;
  logic          is_long;

  cal_engine_if drive_if();
  cal_engine_if term_if();

  function automatic logic [15:0] window_for(input logic long_cmd, input logic first_done);
    if (!long_cmd) begin
      window_for = 16'(SHORT_CYCLES);
    end else if (!first_done) begin
      window_for = 16'(INIT_CYCLES);
    end else begin
      window_for = 16'(FULL_CYCLES);
    end
  endfunction

  // True on the last counted cycle of a window, where the transfer state ends.
  function automatic logic window_closing(input logic [15:0] count);
    window_closing = (count <= 16'h0001);
  endfunction

  // The count stops at zero: a search that overruns a very short window then ends the
  // window at once instead of keeping the block busy for a whole counter period.
  function automatic logic [15:0] count_down(input logic [15:0] count);
    if (count == 16'h0000) begin
      count_down = count;
    end else begin
      count_down = count - 16'h0001;
    end
  endfunction

  // Self refresh exit is deliberately unused: only an explicit command calibrates.
  assign cal_cmd = CMD_VALID && (CMD_CODE == `CAL_CMD_CODE) && (state == IDLE_STATE);
  assign is_long = ADDRESS[`LONG_SELECT_BIT];

  // Both engines run side by side so driver and termination finish together.
  assign drive_if.start = cal_cmd;
  assign term_if.start  = cal_cmd;

  cal_search_engine drive_engine (
    .clock        (CLOCK),
    .rst_n        (RST_N),
    .compare_high (PULLDOWN_COMPARE_HIGH),
    .eng          (drive_if)
  );
  cal_search_engine term_engine (
    .clock        (CLOCK),
    .rst_n        (RST_N),
    .compare_high (TERMINATION_COMPARE_HIGH),
    .eng          (term_if)
  );
  assign drive_result = drive_if.result;
  assign term_result  = term_if.result;

  // Each flag remembers that its engine has reported since the last command.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      drive_done <= 1'b0;
    end else if (cal_cmd) begin
      drive_done <= 1'b0;
    end else if (drive_if.done) begin
      drive_done <= 1'b1;
    end
  end

  // Termination is tracked apart from the driver, since its comparator settles on its own.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      term_done <= 1'b0;
    end else if (cal_cmd) begin
      term_done <= 1'b0;
    end else if (term_if.done) begin
      term_done <= 1'b1;
    end
  end

  // Both codes must be ready before either is applied, so the two settings change together.
  assign search_done = drive_done && term_done;

  // The search is far shorter than the default windows, so the transfer lands inside them; a window shorter than the search ends at once.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      state <= IDLE_STATE;
    end else begin
      case (state)
        IDLE_STATE: begin
          if (cal_cmd) begin
            state <= SEARCH_STATE;
          end
        end
        SEARCH_STATE: begin
          if (search_done) begin
            state <= TRANSFER_STATE;
          end
        end
        TRANSFER_STATE: begin
          if (window_closing(window_count)) begin
            state <= IDLE_STATE;
          end
        end
        default: state <= IDLE_STATE;
      endcase
    end
  end

  // The window is counted from the command, so the search and the transfer share it.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      window_count <= 16'h0000;
    end else if (cal_cmd) begin
      window_count <= window_for(is_long, first_long_done);
    end else if (state != IDLE_STATE) begin
      window_count <= count_down(window_count);
    end
  end

  // Only a long command retires the initial window; a short one leaves it available.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      first_long_done <= 1'b0;
    end else if (cal_cmd && is_long) begin
      first_long_done <= 1'b1;
    end
  end

  // The kind of window stays visible until the transfer state has ended.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      CAL_LONG_ACTIVE <= 1'b0;
    end else if (cal_cmd) begin
      CAL_LONG_ACTIVE <= is_long;
    end else if (state == IDLE_STATE) begin
      CAL_LONG_ACTIVE <= 1'b0;
    end
  end

  // Codes move to the I/O once, at the step into transfer.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      DRIVER_CODE <= `CODE_RESET;
    end else if (state == SEARCH_STATE && search_done) begin
      DRIVER_CODE <= drive_result;
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      TERMINATION_CODE <= `CODE_RESET;
    end else if (state == SEARCH_STATE && search_done) begin
      TERMINATION_CODE <= term_result;
    end
  end

  // The reference current flows only while the engines still compare.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      CAL_CURRENT_ENABLE <= 1'b0;
    end else begin
      CAL_CURRENT_ENABLE <= cal_cmd || (state == SEARCH_STATE && !search_done);
    end
  end

  // Busy covers the whole window so the controller keeps the channel quiet until its end.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      CAL_BUSY <= 1'b0;
    end else begin
      CAL_BUSY <= cal_cmd || (state == SEARCH_STATE)
                  || (state == TRANSFER_STATE && !window_closing(window_count));
    end
  end
endmodule // impedance_calibration

/* File: cal_properties.sv */
// Checker for the impedance calibration sequencer ports.
`timescale 1ns/1ps
module cal_properties #(
  parameter int INIT_CYCLES  = 512,
  parameter int FULL_CYCLES  = 256,
  parameter int SHORT_CYCLES = 64
) (
  input wire logic        CLOCK,
  input wire logic        RST_N,
  input wire logic        CMD_VALID,
  input wire logic [2:0]  CMD_CODE,
  input wire logic [13:0] ADDRESS,
  input wire logic [5:0]  DRIVER_CODE,
  input wire logic        CAL_CURRENT_ENABLE,
  input wire logic        CAL_BUSY,
  input wire logic        CAL_LONG_ACTIVE
);
  logic first_done;
  wire  take = CMD_VALID && CMD_CODE == 3'h6 && !CAL_BUSY;
  // Only the first long window after reset may use the longer bound.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) first_done <= 1'b0;
    else if ($fell(CAL_LONG_ACTIVE)) first_done <= 1'b1;
  end
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  cmd_start_a: assert property (take |=> CAL_BUSY && CAL_CURRENT_ENABLE)
    else $error("calibration did not start");
  long_select_a: assert property (take |=> CAL_LONG_ACTIVE == $past(ADDRESS[10]))
    else $error("wrong calibration kind");
  short_bound_a: assert property ($rose(CAL_BUSY) && !CAL_LONG_ACTIVE |-> ##[1:SHORT_CYCLES] !CAL_BUSY)
    else $error("short window too long");
  init_bound_a: assert property ($rose(CAL_BUSY) && CAL_LONG_ACTIVE && !first_done |-> ##[1:INIT_CYCLES] !CAL_BUSY)
    else $error("initial window too long");
  full_bound_a: assert property ($rose(CAL_BUSY) && CAL_LONG_ACTIVE && first_done |-> ##[1:FULL_CYCLES] !CAL_BUSY)
    else $error("full window too long");
  current_off_a: assert property ($fell(CAL_BUSY) |-> !CAL_CURRENT_ENABLE)
    else $error("current path left on");
  code_hold_a: assert property (!CAL_BUSY && !$past(CAL_BUSY) |-> $stable(DRIVER_CODE))
    else $error("code changed while idle");
  no_self_start_a: assert property ($rose(CAL_BUSY) |-> $past(take))
    else $error("window without command");
endmodule // cal_properties

/* File: cal_controller_model.sv */
// Memory controller model issuing calibration commands.
`timescale 1ns/1ps
module cal_controller_model (
  input  wire logic   clock,
  input  wire logic   busy,
  output logic        cmd_valid,
  output logic [2:0]  cmd_code,
  output logic [13:0] address
);
  initial begin
    cmd_valid = 1'b0;
    cmd_code = 3'h0;
    address = 14'h0;
  end
  // Banks are taken as precharged and clock enable as high throughout; the model drives
  // no termination control and no data, so both stay off during every window.
  task automatic issue(input logic [2:0] code, input logic is_long, input logic wait_idle);
    int n;
    n = 0;
    while (wait_idle && busy !== 1'b0 && n < 1000) begin
      @(negedge clock);
      n++;
    end
    @(negedge clock);
    cmd_valid = 1'b1;
    cmd_code = code;
    address = {3'h0, is_long, 10'h155};
    @(negedge clock);
    cmd_valid = 1'b0;
    cmd_code = ~cmd_code;
    address = ~address;
  endtask
endmodule // cal_controller_model

/* File: tb.sv */
// Self-checking bench for the impedance calibration sequencer.
`timescale 1ns/1ps
module tb;
  localparam int INIT = 48;
  localparam int FULL = 32;
  localparam int SHORT = 16;
  // Self-refresh exit delay as this bench models it; the value is a plain choice.
  localparam int EXIT_DELAY = 20;
  logic clock = 1'b0, rst_n = 1'b0, sr_exit = 1'b0, pd_hi = 1'b1, tm_hi = 1'b0;
  logic cmd_valid, cur, busy, lng;
  logic [2:0] cmd_code;
  logic [13:0] address;
  logic [5:0] drv, trm;
  int num_errors = 0, n_compared = 0, len;
  always #5 clock = ~clock;
  cal_controller_model ctrl (.clock(clock), .busy(busy), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .address(address));
  impedance_calibration #(.INIT_CYCLES(INIT), .FULL_CYCLES(FULL), .SHORT_CYCLES(SHORT)) dut (
    .CLOCK(clock), .RST_N(rst_n), .CMD_VALID(cmd_valid), .CMD_CODE(cmd_code),
    .ADDRESS(address), .SELF_REFRESH_EXIT(sr_exit), .PULLDOWN_COMPARE_HIGH(pd_hi),
    .TERMINATION_COMPARE_HIGH(tm_hi), .DRIVER_CODE(drv), .TERMINATION_CODE(trm),
    .CAL_CURRENT_ENABLE(cur), .CAL_BUSY(busy), .CAL_LONG_ACTIVE(lng));
  task automatic check(input logic ok, input string msg);
    n_compared++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  // Counts busy cycles after a command; the cap keeps a stuck window from hanging.
  task automatic window(input logic is_long, input int limit, input logic [11:0] codes);
    check(busy === 1'b1 && cur === 1'b1 && lng === is_long, "window start");
    len = 0;
    while (busy === 1'b1 && len < 1000) begin
      @(negedge clock);
      len++;
    end
    check(len <= limit, "window length");
    check({drv, trm} === codes && cur === 1'b0, "codes or current");
  endtask
  task automatic t_first_long();
    ctrl.issue(3'h6, 1'b1, 1'b1);
    window(1'b1, INIT, 12'hfc0);
    $display("first long calibration done");
  endtask
  task automatic t_later_long();
    pd_hi = 1'b0;
    tm_hi = 1'b1;
    ctrl.issue(3'h6, 1'b1, 1'b1);
    window(1'b1, FULL, 12'h03f);
    $display("later long calibration done");
  endtask
  task automatic t_short_refused();
    pd_hi = 1'b1;
    ctrl.issue(3'h6, 1'b0, 1'b1);
    ctrl.issue(3'h6, 1'b1, 1'b0);
    check(lng === 1'b0, "command in window taken");
    window(1'b0, SHORT - 2, 12'hfff);
    $display("short calibration done");
  endtask
  task automatic t_sr_exit();
    sr_exit = 1'b1;
    @(negedge clock);
    sr_exit = 1'b0;
    ctrl.issue(3'h5, 1'b1, 1'b1);
    repeat (EXIT_DELAY) @(negedge clock);
    check(busy === 1'b0 && drv === 6'h3f, "self start");
    ctrl.issue(3'h6, 1'b0, 1'b1);
    window(1'b0, SHORT, 12'hfff);
    $display("self refresh exit done");
  endtask
  // A reset between windows restores the codes and reopens the initial long window.
  task automatic t_reset_again();
    rst_n = 1'b0;
    repeat (2) @(negedge clock);
    check({drv, trm} === 12'h820 && {busy, cur, lng} === 3'b000, "reset values");
    rst_n = 1'b1;
    ctrl.issue(3'h6, 1'b1, 1'b1);
    window(1'b1, INIT, 12'hfff);
    $display("second reset done");
  endtask
  task automatic give_verdict();
    $display("compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #20000;
    num_errors++;
    give_verdict();
  end
  initial begin
    repeat (8) @(negedge clock);
    rst_n = 1'b1;
    t_first_long();
    t_later_long();
    t_short_refused();
    t_sr_exit();
    t_reset_again();
    give_verdict();
  end
endmodule // tb
bind impedance_calibration cal_properties #(.INIT_CYCLES(INIT_CYCLES),
  .FULL_CYCLES(FULL_CYCLES), .SHORT_CYCLES(SHORT_CYCLES)) props (.CLOCK(CLOCK),
  .RST_N(RST_N), .CMD_VALID(CMD_VALID), .CMD_CODE(CMD_CODE), .ADDRESS(ADDRESS),
  .DRIVER_CODE(DRIVER_CODE), .CAL_CURRENT_ENABLE(CAL_CURRENT_ENABLE),
  .CAL_BUSY(CAL_BUSY), .CAL_LONG_ACTIVE(CAL_LONG_ACTIVE));
